// ---- hdl/csr_alu.sv ----
// two-byte / one-byte alu of the control processor
`default_nettype none
module csr_alu
  import csr_pkg::*;
(
  input wire logic [0:15] opA,
  input wire logic [0:15] opB,
  input wire csr_alu_op_t aluOp,
  input wire logic byteMode,
  output logic [0:15] result,
  output logic carry
);
  logic [16:0] wide;
  logic [8:0] narrow;

  always_comb
  begin
    wide = 17'h00000;
    narrow = 9'h000;
    case (aluOp)
      ALU_ADD:
      begin
        wide = {1'b0, opA} + {1'b0, opB};
        narrow = {1'b0, opA[8:15]} + {1'b0, opB[8:15]};
      end
      ALU_SUB:
      begin
        wide = {1'b0, opA} - {1'b0, opB};
        narrow = {1'b0, opA[8:15]} - {1'b0, opB[8:15]};
      end
      ALU_AND:
      begin
        wide = {1'b0, opA & opB};
        narrow = {1'b0, opA[8:15] & opB[8:15]};
      end
      ALU_OR:
      begin
        wide = {1'b0, opA | opB};
        narrow = {1'b0, opA[8:15] | opB[8:15]};
      end
      ALU_XOR:
      begin
        wide = {1'b0, opA ^ opB};
        narrow = {1'b0, opA[8:15] ^ opB[8:15]};
      end
      default:
      begin
        wide = {1'b0, opB};
        narrow = {1'b0, opB[8:15]};
      end
    endcase
    // high byte passes operand a untouched in byte mode
    result = byteMode ? {opA[0:7], narrow[7:0]} : wide[15:0];
    carry = byteMode ? narrow[8] : wide[16];
  end
endmodule : csr_alu
`default_nettype wire

// ---- hdl/csr_control_status_regs.sv ----
// control, status and local register logic of the control processor
`default_nettype none
module csr_control_status_regs
  import csr_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire csr_uinst_t uinst,
  input wire logic uStep,
  input wire logic [0:15] curAddr,
  input wire logic branchLink,
  input wire csr_op_t op,
  input wire logic [0:7] rcbWrData,
  input wire logic levelWr,
  input wire logic [0:7] levelIn,
  input wire logic [0:7] storErrIn,
  input wire logic forceRunPin,
  input wire logic jumperPin,
  input wire logic panelResetPin,
  input wire logic csMatch,
  input wire logic msMatch,
  input wire logic panelStop,
  input wire csr_sense_t senseSel,
  input wire logic jumpTest,
  input wire logic [0:7] jumpMask,
  input wire logic [6:0] dumpIdx,
  input wire logic [3:0] csSel,
  input wire logic csWrEn,
  input wire logic [0:15] csWrData,
  output logic [0:7] senseData,
  output logic mspStop,
  output logic cspHalted,
  output logic mchkReq,
  output logic jumpTaken,
  output logic [0:15] dumpData,
  output logic [0:15] csAddrOut
);
  typedef enum logic [1:0] {
    ST_RUN = 2'b01,
    ST_HALT = 2'b10
  } csr_state_t;

  csr_state_t state_reg;
  csr_state_t state_next;
  logic [0:7] errByte_reg;
  logic [0:7] errByte_next;
  logic [0:7] rcb_reg;
  logic [0:7] level_reg;
  logic [0:7] cond_reg;
  logic chkOff_reg;
  logic [2:0] pinMeta_reg;
  logic [2:0] pinSync_reg;
  logic [0:15] localRegs [NUM_LOCAL];
  logic [0:15] csAddrRegs [CS_REGS];
  logic [2:0] bank;
  logic [6:0] marIdx;
  logic [6:0] mabIdx;
  logic [6:0] idxA;
  logic [6:0] idxB;
  logic [6:0] dstIdx;
  logic [0:15] portA;
  logic [0:15] portB;
  logic [0:15] aluRes;
  logic aluCarry;
  logic checksDisabled;
  logic panelReset;
  logic errClear;
  logic cmpHit;

  // pins from panel and jumper pass two flops before use
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      pinMeta_reg <= 3'h0;
      pinSync_reg <= 3'h0;
    end
    else
    begin
      pinMeta_reg <= {panelResetPin, jumperPin, forceRunPin};
      pinSync_reg <= pinMeta_reg;
    end
  end

  assign panelReset = pinSync_reg[2];
  assign checksDisabled = chkOff_reg | pinSync_reg[1] | pinSync_reg[0];

  // checks disabled by an immediate command until re-enabled
  always_ff @(posedge clk)
  begin
    if (srst)
      chkOff_reg <= 1'b0;
    else if (op == OP_CHK_OFF)
      chkOff_reg <= 1'b1;
    else if (op == OP_CHK_ON)
      chkOff_reg <= 1'b0;
  end

  assign errClear = (op == OP_RST_MCHK) | panelReset;

  always_comb
  begin
    errByte_next = errClear ? ERR_RESET : errByte_reg;
    errByte_next = errByte_next | storErrIn; // new error beats clear
  end

  always_ff @(posedge clk)
  begin
    if (srst)
      errByte_reg <= ERR_RESET;
    else
      errByte_reg <= errByte_next;
  end

  always_ff @(posedge clk)
  begin
    if (srst)
      mchkReq <= 1'b0;
    else if (|storErrIn && !checksDisabled)
      mchkReq <= 1'b1;
    else if (errClear)
      mchkReq <= 1'b0;
  end

  assign cmpHit = rcb_reg[RCB_CMP_EN] &
                  (rcb_reg[RCB_CMP_CS] ? csMatch : msMatch);

  // halt state: stays stopped until a resume command
  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      ST_RUN:
        if (cmpHit || panelStop)
          state_next = ST_HALT;
      ST_HALT:
        if (op == OP_RESUME)
          state_next = ST_RUN;
      default:
        state_next = ST_RUN;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (srst)
      state_reg <= ST_RUN;
    else
      state_reg <= state_next;
  end

  assign cspHalted = state_reg[1];

  // run control byte; stop reasons latch on entry to halt
  always_ff @(posedge clk)
  begin
    if (srst)
      rcb_reg <= RCB_RESET;
    else
    begin
      if (op == OP_SET_STOP)
        rcb_reg[RCB_STOP] <= 1'b1;
      else if (op == OP_RST_STOP || op == OP_PROC_RESET)
        rcb_reg[RCB_STOP] <= 1'b0;
      if (op == OP_SET_SVC)
        rcb_reg[RCB_SVC] <= 1'b1;
      else if (op == OP_RST_SVC || op == OP_PROC_RESET)
        rcb_reg[RCB_SVC] <= 1'b0;
      if (op == OP_WR_RCB)
        rcb_reg[RCB_CMP_EN:RCB_CMP_CS] <=
          rcbWrData[RCB_CMP_EN:RCB_CMP_CS];
      if (state_reg == ST_RUN && cmpHit)
        rcb_reg[RCB_CMP_HIT] <= 1'b1;
      else if (op == OP_RESUME)
        rcb_reg[RCB_CMP_HIT] <= 1'b0;
      // panel stop cause; 5 and 7 fixed
      if (state_reg == ST_RUN && panelStop)
        rcb_reg[RCB_PANEL] <= 1'b1;
      else if (op == OP_RESUME)
        rcb_reg[RCB_PANEL] <= 1'b0;
      rcb_reg[RCB_ONE5] <= 1'b1;
      rcb_reg[RCB_ONE7] <= 1'b1;
    end
  end

  // stop to the main processor, one flop behind the latches
  always_ff @(posedge clk)
  begin
    if (srst)
      mspStop <= 1'b0;
    else
      mspStop <= rcb_reg[RCB_STOP] | rcb_reg[RCB_SVC];
  end

  always_ff @(posedge clk)
  begin
    if (srst)
      level_reg <= LEVEL_RESET;
    else if (levelWr)
      level_reg <= levelIn & LEVEL_USED;
  end

  assign bank = csr_bank(level_reg);
  assign marIdx = csr_gidx(bank, IDX_MAR);
  assign mabIdx = csr_gidx(bank, IDX_MAB);
  assign idxA = csr_gidx(bank, uinst.srcA);
  assign idxB = csr_gidx(bank, uinst.srcB);
  assign dstIdx = csr_gidx(bank, uinst.dst);
  // two read ports feed the alu
  assign portA = localRegs[idxA];
  assign portB = localRegs[idxB];

  csr_alu u_alu (
    .opA(portA),
    .opB(portB),
    .aluOp(uinst.aluOp),
    .byteMode(uinst.byteMode),
    .result(aluRes),
    .carry(aluCarry)
  );

  // one flat array of 72 halfwords
  // register data is not reset; software loads it before use
  always_ff @(posedge clk)
  begin
    // address register tracks address plus one
    if (uStep)
      localRegs[marIdx] <= curAddr + 16'h0001;
    if (branchLink)
      localRegs[mabIdx] <= localRegs[marIdx];
    if (uinst.wrEn)
      localRegs[dstIdx] <= aluRes;
  end

  always_ff @(posedge clk)
  begin
    if (srst)
      cond_reg <= 8'h00;
    else if (uinst.condUpd)
    begin
      cond_reg <= 8'h00;
      cond_reg[COND_ZERO] <= uinst.byteMode ? (aluRes[8:15] == 8'h00)
                                            : (aluRes == 16'h0000);
      cond_reg[COND_CARRY] <= aluCarry;
      cond_reg[COND_SIGN] <= uinst.byteMode ? aluRes[8] : aluRes[0];
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
      jumpTaken <= 1'b0;
    else
      jumpTaken <= jumpTest & |(cond_reg & jumpMask);
  end

  // control and run control sense both return the run control byte
  always_ff @(posedge clk)
  begin
    if (srst)
      senseData <= 8'h00;
    else
      case (senseSel)
        SNS_STOR_ERR: senseData <= errByte_reg;
        SNS_CTRL: senseData <= rcb_reg;
        SNS_RCB: senseData <= rcb_reg;
        SNS_LEVEL: senseData <= level_reg;
        SNS_COND: senseData <= cond_reg;
        default: senseData <= 8'h00;
      endcase
  end

  always_ff @(posedge clk)
  begin
    if (srst)
      dumpData <= 16'h0000;
    else if (cspHalted && dumpIdx < 7'(NUM_LOCAL))
      dumpData <= localRegs[dumpIdx];
    else
      dumpData <= 16'h0000;
  end

  always_ff @(posedge clk)
  begin
    if (csWrEn)
      csAddrRegs[csSel] <= csWrData;
  end

  always_ff @(posedge clk)
  begin
    if (srst)
      csAddrOut <= 16'h0000;
    else
      csAddrOut <= csAddrRegs[csSel];
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);

  a_err_flag_set: assert property (
    |storErrIn |=> (errByte_reg & $past(storErrIn)) == $past(storErrIn))
    else $error("storage error flag not recorded");

  a_mchk_raise: assert property (
    (|storErrIn && !checksDisabled) |=> mchkReq ##1 mchkReq || errClear)
    else $error("machine check not raised");

  a_err_clear: assert property (
    (op == OP_RST_MCHK && storErrIn == 8'h00) |=> errByte_reg == 8'h00)
    else $error("error byte not cleared");

  a_err_keep_load: assert property (
    (op == OP_LOAD && storErrIn == 8'h00 && !panelReset)
      |=> errByte_reg == $past(errByte_reg))
    else $error("load changed error byte");

  a_sense_err: assert property (
    senseSel == SNS_STOR_ERR |=> senseData == $past(errByte_reg))
    else $error("sense of error byte wrong");

  a_stop_path: assert property (
    op == OP_SET_STOP |=> rcb_reg[RCB_STOP] ##1 mspStop)
    else $error("stop bit did not stop main processor");

  a_rcb_fixed: assert property (
    $past(srst) || (rcb_reg[RCB_ONE5] && rcb_reg[RCB_ONE7]))
    else $error("fixed run control bits not one");

  a_cmp_halt: assert property (
    (state_reg == ST_RUN && rcb_reg[RCB_CMP_EN] && rcb_reg[RCB_CMP_CS]
      && csMatch) |=> cspHalted && rcb_reg[RCB_CMP_HIT])
    else $error("address compare did not halt");

  a_mar_step: assert property (
    (uStep && !branchLink && !(uinst.wrEn && dstIdx == marIdx) && !levelWr)
      |=> localRegs[marIdx] == $past(curAddr) + 16'h0001)
    else $error("address register not current plus one");

  a_mab_link: assert property (
    (branchLink && !(uinst.wrEn && dstIdx == mabIdx) && !levelWr)
      |=> localRegs[mabIdx] == $past(localRegs[marIdx]))
    else $error("link did not save return address");
endmodule : csr_control_status_regs
`default_nettype wire

// ---- shared/csr_pkg.sv ----
// constants, types and helpers for the control/status register block
`default_nettype none
package csr_pkg;
  // local register layout
  localparam int BANK_REGS = 10;
  localparam int NUM_LOCAL = 72;
  localparam int BASE_DISP_IDX = 70;
  localparam int CS_REGS = 16;
  localparam logic [2:0] MCHK_BANK = 3'h6;
  localparam logic [3:0] IDX_MAR = 4'h8;
  localparam logic [3:0] IDX_MAB = 4'h9;
  localparam logic [3:0] IDX_BASE = 4'hA;
  // run control byte bits, bit 0 is the most significant
  localparam int RCB_STOP = 0;
  localparam int RCB_CMP_EN = 1;
  localparam int RCB_CMP_CS = 2;
  localparam int RCB_CMP_HIT = 3;
  localparam int RCB_SVC = 4;
  localparam int RCB_ONE5 = 5;
  localparam int RCB_PANEL = 6;
  localparam int RCB_ONE7 = 7;
  localparam logic [0:7] RCB_RESET = 8'h05;
  localparam logic [0:7] RCB_WR_MASK = 8'h60;
  localparam logic [0:7] ERR_RESET = 8'h00;
  localparam logic [0:7] LEVEL_RESET = 8'h07;
  localparam logic [0:7] LEVEL_USED = 8'h0F;
  localparam int LVL_MCHK_BIT = 4;
  // level codes in level byte bits 5-7
  localparam logic [2:0] LVL_MAIN = 3'h7;
  localparam logic [2:0] LVL_1 = 3'h5;
  localparam logic [2:0] LVL_2 = 3'h4;
  localparam logic [2:0] LVL_3 = 3'h3;
  localparam logic [2:0] LVL_4 = 3'h1;
  localparam logic [2:0] LVL_5 = 3'h0;
  // condition register bits
  localparam int COND_ZERO = 0;
  localparam int COND_CARRY = 1;
  localparam int COND_SIGN = 2;

  typedef enum logic [3:0] {
    OP_NONE = 4'h0, OP_SET_STOP = 4'h1, OP_RST_STOP = 4'h2,
    OP_SET_SVC = 4'h3, OP_RST_SVC = 4'h4, OP_PROC_RESET = 4'h5,
    OP_RST_MCHK = 4'h6, OP_CHK_OFF = 4'h7, OP_CHK_ON = 4'h8,
    OP_LOAD = 4'h9, OP_WR_RCB = 4'hA, OP_RESUME = 4'hB
  } csr_op_t;

  typedef enum logic [2:0] {
    SNS_NONE = 3'h0, SNS_STOR_ERR = 3'h1, SNS_CTRL = 3'h2,
    SNS_RCB = 3'h3, SNS_LEVEL = 3'h4, SNS_COND = 3'h5
  } csr_sense_t;

  typedef enum logic [2:0] {
    ALU_MOVE = 3'h0, ALU_ADD = 3'h1, ALU_SUB = 3'h2,
    ALU_AND = 3'h3, ALU_OR = 3'h4, ALU_XOR = 3'h5
  } csr_alu_op_t;

  // microinstruction fields that steer the alu and register set
  typedef struct packed {
    csr_alu_op_t aluOp;
    logic byteMode;
    logic [3:0] srcA;
    logic [3:0] srcB;
    logic [3:0] dst;
    logic wrEn;
    logic condUpd;
  } csr_uinst_t;

  // bank of the active level; cycle steal shares the main bank
  function automatic logic [2:0] csr_bank(input logic [0:7] lvb);
    logic [2:0] b;
    b = 3'h0;
    if (lvb[LVL_MCHK_BIT])
      b = MCHK_BANK;
    else
      case (lvb[5:7])
        LVL_1: b = 3'h1;
        LVL_2: b = 3'h2;
        LVL_3: b = 3'h3;
        LVL_4: b = 3'h4;
        LVL_5: b = 3'h5;
        default: b = 3'h0;
      endcase
    return b;
  endfunction : csr_bank

  // flat index of a register; 10 and up reach the base registers
  function automatic logic [6:0] csr_gidx(input logic [2:0] bank,
                                          input logic [3:0] idx);
    logic [6:0] g;
    g = 7'(BASE_DISP_IDX) + {6'h00, idx[0]};
    if (idx < IDX_BASE)
      g = 7'(int'(bank) * BANK_REGS) + {3'h0, idx};
    return g;
  endfunction : csr_gidx
endpackage : csr_pkg
`default_nettype wire

// ---- sim/csr_chan_model.sv ----
// channel-side model that steers the cycle steal address registers
`default_nettype none
module csr_chan_model
  import csr_pkg::*;
(
  input wire logic clk,
  output logic [3:0] csSel,
  output logic csWrEn,
  output logic [0:15] csWrData,
  input wire logic [0:15] csAddrOut
);
  timeunit 1ns;
  timeprecision 1ps;

  // idle channel: nothing selected for writing
  initial
  begin
    csSel = 4'h0;
    csWrEn = 1'b0;
    csWrData = 16'h0000;
  end

  task automatic steal_write(input logic [3:0] sel, input logic [0:15] d);
    @(negedge clk);
    csSel = sel;
    csWrData = d;
    csWrEn = 1'b1;
    @(negedge clk);
    csWrEn = 1'b0;
    csWrData = ~d; // released data never shows the stale value
  endtask : steal_write

  task automatic steal_read(input logic [3:0] sel, output logic [0:15] d);
    @(negedge clk);
    csSel = sel;
    repeat (2) @(negedge clk);
    d = csAddrOut;
  endtask : steal_read
endmodule : csr_chan_model
`default_nettype wire

// ---- sim/tb_csr_control_status_regs.sv ----
// self-checking bench for the control/status register block
`default_nettype none
module tb_csr_control_status_regs
  import csr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    csr_op_t op;
    logic [0:7] wr;
    logic [0:7] run_control_byte;
    logic stop;
  } csr_row_t;
  logic clk, srst, uStep, branchLink, levelWr, forceRunPin, jumperPin;
  logic panelResetPin, csMatch, msMatch, panelStop, jumpTest, csWrEn;
  logic mspStop, cspHalted, mchkReq, jumpTaken;
  csr_uinst_t uinst;
  csr_op_t op;
  csr_sense_t senseSel;
  logic [0:15] curAddr, csWrData, dumpData, csAddrOut, w;
  logic [0:7] rcbWrData, levelIn, storErrIn, jumpMask, senseData, s;
  logic [6:0] dumpIdx;
  logic [3:0] csSel;
  int num_errors = 0;
  int tests_run = 0;
  csr_row_t rows [11];

  csr_control_status_regs DUT (.clk(clk), .srst(srst), .uinst(uinst),
    .uStep(uStep), .curAddr(curAddr), .branchLink(branchLink), .op(op),
    .rcbWrData(rcbWrData), .levelWr(levelWr), .levelIn(levelIn),
    .storErrIn(storErrIn), .forceRunPin(forceRunPin),
    .jumperPin(jumperPin), .panelResetPin(panelResetPin),
    .csMatch(csMatch), .msMatch(msMatch), .panelStop(panelStop),
    .senseSel(senseSel), .jumpTest(jumpTest), .jumpMask(jumpMask),
    .dumpIdx(dumpIdx), .csSel(csSel), .csWrEn(csWrEn),
    .csWrData(csWrData), .senseData(senseData), .mspStop(mspStop),
    .cspHalted(cspHalted), .mchkReq(mchkReq), .jumpTaken(jumpTaken),
    .dumpData(dumpData), .csAddrOut(csAddrOut));
  csr_chan_model u_chan (.clk(clk), .csSel(csSel), .csWrEn(csWrEn),
    .csWrData(csWrData), .csAddrOut(csAddrOut));

  // 50 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic tally_and_finish();
    $display("checks %0d, mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : tally_and_finish

  task automatic report(input logic ok, input logic [0:15] g, e);
    tests_run++;
    if (!ok)
    begin
      num_errors++;
      $display("[FAIL] t=%0t got %h exp %h", $time, g, e);
    end
  endtask : report
  task automatic chk8(input logic [0:7] g, input logic [0:7] e);
    report(g === e, {8'h00, g}, {8'h00, e});
  endtask : chk8
  task automatic chk1(input logic g, input logic e);
    report(g === e, {15'h0000, g}, {15'h0000, e});
  endtask : chk1
  task automatic chk16(input logic [0:15] g, input logic [0:15] e);
    report(g === e, g, e);
  endtask : chk16

  // sense is resampled every cycle, so hold the selector and wait
  task automatic sense(input csr_sense_t sel, output logic [0:7] d);
    @(negedge clk);
    senseSel = sel;
    repeat (2) @(negedge clk);
    d = senseData;
  endtask : sense
  task automatic do_op(input csr_op_t o, input logic [0:7] wr);
    @(negedge clk);
    op = o;
    rcbWrData = wr;
    @(negedge clk);
    op = OP_NONE;
    repeat (2) @(negedge clk);
  endtask : do_op
  task automatic err(input logic [0:7] v);
    @(negedge clk);
    storErrIn = v;
    @(negedge clk);
    storErrIn = 8'h00;
    repeat (2) @(negedge clk);
  endtask : err
  task automatic pulse(ref logic sig);
    @(negedge clk);
    sig = 1'b1;
    @(negedge clk);
    sig = 1'b0;
    repeat (2) @(negedge clk);
  endtask : pulse
  task automatic step(input logic [0:15] a);
    curAddr = a;
    pulse(uStep);
  endtask : step
  task automatic alu(input csr_alu_op_t o, input logic bm, input logic [3:0] a,
                     input logic [3:0] b, input logic [3:0] d, input logic cu);
    @(negedge clk);
    uinst = '{aluOp:o, byteMode:bm, srcA:a, srcB:b, dst:d, wrEn:!cu,
              condUpd:cu};
    @(negedge clk);
    uinst = '0;
  endtask : alu
  task automatic dump(input logic [6:0] i, input logic [0:15] e);
    dumpIdx = i;
    repeat (2) @(negedge clk);
    chk16(dumpData, e);
  endtask : dump

  // watchdog well beyond the expected run of a few hundred cycles
  initial
  begin
    repeat (5000) @(posedge clk);
    num_errors++;
    tally_and_finish();
  end

  initial
  begin
    rows = '{'{OP_SET_STOP, 8'h00, 8'h85, 1'b1},
             '{OP_SET_SVC, 8'h00, 8'h8D, 1'b1},
             '{OP_RST_STOP, 8'h00, 8'h0D, 1'b1},
             '{OP_RST_SVC, 8'h00, 8'h05, 1'b0},
             '{OP_SET_SVC, 8'h00, 8'h0D, 1'b1},
             '{OP_PROC_RESET, 8'h00, 8'h05, 1'b0},
             '{OP_SET_STOP, 8'h00, 8'h85, 1'b1},
             '{OP_PROC_RESET, 8'h00, 8'h05, 1'b0},
             '{OP_WR_RCB, 8'hFF, 8'h65, 1'b0},
             '{OP_WR_RCB, 8'h00, 8'h05, 1'b0},
             '{OP_LOAD, 8'h00, 8'h05, 1'b0}};
    {srst, uStep, branchLink, levelWr, forceRunPin, jumperPin} = 6'h3F & 6'h20;
    {panelResetPin, csMatch, msMatch, panelStop, jumpTest} = 5'h00;
    uinst = '0;
    op = OP_NONE;
    senseSel = SNS_NONE;
    curAddr = 16'h0000;
    {rcbWrData, levelIn, storErrIn, jumpMask} = 32'h0000_0000;
    dumpIdx = 7'h00;
    repeat (8) @(negedge clk);
    srst = 1'b0;
    // reset values
    sense(SNS_RCB, s);
    chk8(s, 8'h05);
    sense(SNS_LEVEL, s);
    chk8(s, 8'h07);
    chk1(mspStop, 1'b0);
    $display("reset test done");
    // run control commands, table driven
    foreach (rows[i])
    begin
      do_op(rows[i].op, rows[i].wr);
      sense(SNS_RCB, s);
      chk8(s, rows[i].run_control_byte);
      sense(SNS_CTRL, s);
      chk8(s, rows[i].run_control_byte);
      chk1(mspStop, rows[i].stop);
    end
    $display("run control rows done");
    // storage error byte
    err(8'h80);
    chk1(mchkReq, 1'b1);
    do_op(OP_LOAD, 8'h00);
    sense(SNS_STOR_ERR, s);
    chk8(s, 8'h80);
    do_op(OP_RST_MCHK, 8'h00);
    sense(SNS_STOR_ERR, s);
    chk8(s, 8'h00);
    chk1(mchkReq, 1'b0);
    do_op(OP_CHK_OFF, 8'h00);
    err(8'h21);
    sense(SNS_STOR_ERR, s);
    chk8(s, 8'h21);
    chk1(mchkReq, 1'b0);
    do_op(OP_CHK_ON, 8'h00);
    pulse(panelResetPin);
    repeat (2) @(negedge clk);
    sense(SNS_STOR_ERR, s);
    chk8(s, 8'h00);
    forceRunPin = 1'b1;
    repeat (3) @(negedge clk);
    err(8'h02);
    chk1(mchkReq, 1'b0);
    forceRunPin = 1'b0;
    pulse(srst);
    sense(SNS_STOR_ERR, s);
    chk8(s, 8'h00);
    $display("error byte test done");
    // address compare stops
    do_op(OP_WR_RCB, 8'h60);
    pulse(msMatch);
    chk1(cspHalted, 1'b0);
    pulse(csMatch);
    chk1(cspHalted, 1'b1);
    sense(SNS_RCB, s);
    chk8(s, 8'h75);
    do_op(OP_RESUME, 8'h00);
    chk1(cspHalted, 1'b0);
    do_op(OP_WR_RCB, 8'h40);
    pulse(msMatch);
    chk1(cspHalted, 1'b1);
    do_op(OP_RESUME, 8'h00);
    do_op(OP_WR_RCB, 8'h00);
    pulse(csMatch);
    chk1(cspHalted, 1'b0);
    $display("compare test done");
    // register set, alu and level banks
    step(16'h1233);
    pulse(branchLink);
    step(16'h2000);
    alu(ALU_ADD, 1'b0, IDX_MAR, IDX_MAB, 4'h0, 1'b0);
    alu(ALU_ADD, 1'b1, IDX_MAR, IDX_MAB, 4'h1, 1'b0);
    alu(ALU_MOVE, 1'b0, IDX_MAB, IDX_MAB, IDX_BASE, 1'b0);
    alu(ALU_SUB, 1'b0, IDX_MAB, IDX_MAB, 4'h0, 1'b1);
    sense(SNS_COND, s);
    chk1(s[COND_ZERO], 1'b1);
    jumpMask = 8'h80;
    jumpTest = 1'b1;
    repeat (2) @(negedge clk);
    chk1(jumpTaken, 1'b1);
    jumpTest = 1'b0;
    levelIn = 8'h05;
    pulse(levelWr);
    step(16'h00FF);
    levelIn = 8'h07;
    pulse(levelWr);
    pulse(panelStop);
    chk1(cspHalted, 1'b1);
    sense(SNS_RCB, s);
    chk8(s, 8'h07);
    dump(7'd8, 16'h2001);
    dump(7'd9, 16'h1234);
    dump(7'd0, 16'h3235);
    dump(7'd1, 16'h2035);
    dump(7'd70, 16'h1234);
    dump(7'd18, 16'h0100);
    do_op(OP_RESUME, 8'h00);
    dump(7'd8, 16'h0000);
    $display("register set test done");
    // cycle steal registers through the channel model
    u_chan.steal_write(4'h5, 16'hBEEF);
    u_chan.steal_write(4'hC, 16'h1357);
    u_chan.steal_read(4'h5, w);
    chk16(w, 16'hBEEF);
    u_chan.steal_read(4'hC, w);
    chk16(w, 16'h1357);
    $display("cycle steal test done");
    tally_and_finish();
  end
endmodule : tb_csr_control_status_regs
`default_nettype wire
